// ==== pbg_port.sv ====
// Port B pin block: latch, direction, pull-ups, analog choice,
// change detection and pin overrides for capture and programming.
// Assumes a register master that never waits and synchronous straps.
//
// Summary of operation
// - Output pin 4 drives its latch bit even when analog is selected.
// - Input pin 4 reads its level; pull-up when enabled; analog kills input.
// - Input pins 5 to 7 read levels, pull-up when global control cleared.
// - After reset low pins start analog or digital per the strap.
// - Pin select 0 routes capture unit 2 through pin 3 both ways.
// - Low-voltage programming makes pin 5 the mode entry input; port reads still show it.
// - Programming or debug makes pins 6 and 7 clock and data; port reads still show them.
// - Pin 7 is driven and sampled by the device; tool clocks pin 6.
// - Latch register reads and writes the latch, not the pins.
// - Unimplemented bits read 0 and ignore writes.
// - Input pins 4 to 7 compare to reference; OR sets change flag.
// - Port access recaptures the reference; mismatch keeps setting flag.
// - Pull-ups off after reset and on any output pin.
// - Direction 1 floats the driver; 0 drives the latch value.
//
// Chosen here: the address-and-strobe port and the register offsets.
module pbg_port
  import pbg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [pbg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pbg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [pbg_pkg::DATA_W-1:0] reg_rdata,
  // Configuration straps
  input wire logic por_analog_default,
  input wire logic capture_unit2_pin_select,
  input wire logic low_voltage_prog_enable,
  input wire logic debug_prog_enable,
  // Pins
  input wire logic [pbg_pkg::PIN_N-1:0] pin_in,
  output logic [pbg_pkg::PIN_N-1:0] pin_out,
  output logic [pbg_pkg::PIN_N-1:0] pin_oe,
  output logic [pbg_pkg::PIN_N-1:0] pin_pullup_en,
  output logic [pbg_pkg::ANALOG_N-1:0] pin_analog_en,
  // Capture unit 2
  input wire logic capture_unit2_compare,
  output logic capture_unit2_capture,
  // Programming engine
  input wire logic prog_data_drive,
  input wire logic prog_data_drive_en,
  output logic prog_data_sample,
  output logic prog_serial_clock,
  output logic prog_mode_entry,
  // Interrupts
  output logic irq,
  output logic port_change_irq_high,
  output logic port_change_irq_low
);

  // ****************************************************************
  // Decoding
  // ****************************************************************

  // Low pins that the converter field hands to analog
  function automatic logic [ANALOG_N-1:0] analog_mask(input logic [3:0] field);
    logic [ANALOG_N-1:0] mask;
    mask = '0;
    for (int i = 0; i < ANALOG_N; i++)
    begin
      mask[i] = (field < ANALOG_LIMIT[i]);
    end
    return mask;
  endfunction : analog_mask

  // ****************************************************************
  // State
  // ****************************************************************
  pbg_state_t state;
  pbg_state_t next_state;
  logic [7:0] latch;
  logic [7:0] next_latch;
  logic [7:0] direction;
  logic [7:0] next_direction;
  logic [7:0] int_main;
  logic [7:0] next_int_main;
  logic [7:0] int_edges;
  logic [7:0] next_int_edges;
  logic [7:0] int_external;
  logic [7:0] next_int_external;
  logic [7:0] analog_cfg;
  logic [7:0] next_analog_cfg;
  logic [STAT_W-1:0] irq_status;
  logic [STAT_W-1:0] next_irq_status;
  logic [STAT_W-1:0] irq_enable;
  logic [STAT_W-1:0] next_irq_enable;
  logic [7:0] next_rdata;
  logic entry_seen;
  logic change_seen;

  // Pin side next values
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  logic [7:0] next_pullup;
  logic [ANALOG_N-1:0] next_analog_en;
  logic next_capture;
  logic next_sample;
  logic next_prog_clock;
  logic next_entry;
  logic next_irq;
  logic next_irq_high;
  logic next_irq_low;

  // Shared decodes
  logic [ANALOG_N-1:0] analog_now;
  logic [7:0] analog_wide;
  logic [7:0] taken_over;
  logic [7:0] pin_read;
  logic port_access;

  pbg_sense_if sense ();

  pbg_change_sense u_sense (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_in(pin_in),
    .sense(sense)
  );

  // ****************************************************************
  // Overrides and pin read value
  // ****************************************************************

  // Pins claimed by programming drop out of the change comparison; port reads still show them
  always_comb
  begin
    analog_now = analog_mask(analog_cfg[3:0]);
    analog_wide = {3'h0, analog_now};
    taken_over = 8'h00;
    taken_over[PIN_PROG_ENTRY] = low_voltage_prog_enable;
    taken_over[PIN_PROG_CLOCK] = debug_prog_enable;
    taken_over[PIN_PROG_DATA] = debug_prog_enable;
    // Analog inputs read 0 since their digital buffer is off
    pin_read = sense.pin_sync & ~(analog_wide & direction);
  end

  // Any port access ends the mismatch; only live digital inputs compare
  assign port_access = (reg_read | reg_write) && (reg_addr == OFS_PIN_LEVELS);
  assign sense.recapture = port_access;
  assign sense.compare_mask = direction[7:4] & ~taken_over[7:4] & ~analog_wide[7:4];

  // Sticky events: a standing mismatch and a programming entry request
  assign change_seen = sense.mismatch;
  assign entry_seen = low_voltage_prog_enable && sense.pin_sync[PIN_PROG_ENTRY]
    && !prog_mode_entry;

  // ****************************************************************
  // Register next values
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_latch = latch;
    next_direction = direction;
    next_int_main = int_main;
    next_int_edges = int_edges;
    next_int_external = int_external;
    next_analog_cfg = analog_cfg;
    next_irq_status = irq_status;
    next_irq_enable = irq_enable;
    next_rdata = 8'h00;
    // The strap is taken in the first cycle after reset is released
    case (state)
      PBG_ST_LOAD:
      begin
        if (por_analog_default)
        begin
          next_analog_cfg = ANALOG_CFG_ALL_ANALOG;
        end
        else
        begin
          next_analog_cfg = ANALOG_CFG_ALL_DIGITAL;
        end
        next_state = PBG_ST_RUN;
      end
      PBG_ST_RUN:
      begin
        next_state = PBG_ST_RUN;
      end
      default:
      begin
        next_state = PBG_ST_LOAD;
      end
    endcase
    // Writes keep only implemented bits
    if (reg_write)
    begin
      case (reg_addr)
        OFS_PIN_LEVELS: next_latch = reg_wdata;
        OFS_OUTPUT_LATCH: next_latch = reg_wdata;
        OFS_DIRECTION: next_direction = reg_wdata;
        OFS_INT_MAIN: next_int_main = reg_wdata & INT_MAIN_MASK;
        OFS_INT_EDGES: next_int_edges = reg_wdata & INT_EDGES_MASK;
        OFS_INT_EXTERNAL: next_int_external = reg_wdata & INT_EXTERNAL_MASK;
        OFS_ANALOG_CFG: next_analog_cfg = reg_wdata & ANALOG_CFG_MASK;
        OFS_IRQ_CLEAR: next_irq_status = irq_status & ~reg_wdata[STAT_W-1:0];
        OFS_IRQ_ENABLE: next_irq_enable = reg_wdata[STAT_W-1:0];
        default: next_latch = latch;
      endcase
    end
    // Hardware sets win over a clear in the same cycle
    if (change_seen)
    begin
      next_int_main[CHANGE_FLAG_BIT] = 1'b1;
      next_irq_status[STAT_CHANGE_BIT] = 1'b1;
    end
    if (entry_seen)
    begin
      next_irq_status[STAT_PROG_ENTRY_BIT] = 1'b1;
    end
    // Read data stands only in the cycle after the strobe
    if (reg_read)
    begin
      case (reg_addr)
        OFS_PIN_LEVELS: next_rdata = pin_read;
        OFS_OUTPUT_LATCH: next_rdata = latch;
        OFS_DIRECTION: next_rdata = direction;
        OFS_INT_MAIN: next_rdata = int_main;
        OFS_INT_EDGES: next_rdata = int_edges;
        OFS_INT_EXTERNAL: next_rdata = int_external;
        OFS_ANALOG_CFG: next_rdata = analog_cfg;
        OFS_IRQ_STATUS: next_rdata = {6'h00, irq_status};
        OFS_IRQ_ENABLE: next_rdata = {6'h00, irq_enable};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Registers; pull-ups start off and low pins wait for the strap
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= PBG_ST_LOAD;
      latch <= LATCH_RST;
      direction <= DIRECTION_RST;
      int_main <= INT_MAIN_RST;
      int_edges <= INT_EDGES_RST;
      int_external <= INT_EXTERNAL_RST;
      analog_cfg <= ANALOG_CFG_ALL_ANALOG;
      irq_status <= STAT_RST;
      irq_enable <= STAT_RST;
      reg_rdata <= 8'h00;
    end
    else
    begin
      state <= next_state;
      latch <= next_latch;
      direction <= next_direction;
      int_main <= next_int_main;
      int_edges <= next_int_edges;
      int_external <= next_int_external;
      analog_cfg <= next_analog_cfg;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Pin drive, pull-ups and side signals
  // ****************************************************************

  // Plain port behaviour per pin, then the overrides on top
  always_comb
  begin
    for (int i = 0; i < PIN_N; i++)
    begin
      next_pin_out[i] = latch[i];
      next_pin_oe[i] = ~direction[i];
      // Pull-up only on inputs, with the global control cleared
      next_pullup[i] = direction[i] & ~int_edges[PULLUP_OFF_BIT];
    end
    // Analog inputs lose their pull-up; output drive is untouched
    next_pullup[ANALOG_N-1:0] = next_pullup[ANALOG_N-1:0] & ~analog_now;
    next_analog_en = analog_now & direction[ANALOG_N-1:0];
    // Capture unit 2 on pin 3 when its select is low
    next_capture = 1'b0;
    if (!capture_unit2_pin_select)
    begin
      next_pin_out[PIN_CAPTURE] = capture_unit2_compare;
      next_capture = direction[PIN_CAPTURE] & sense.pin_sync[PIN_CAPTURE];
    end
    // Entry pin is a pure input while low-voltage programming is on
    next_entry = 1'b0;
    if (low_voltage_prog_enable)
    begin
      next_pin_oe[PIN_PROG_ENTRY] = 1'b0;
      next_pullup[PIN_PROG_ENTRY] = 1'b0;
      next_entry = sense.pin_sync[PIN_PROG_ENTRY];
    end
    // Clock comes from the tool; data is driven by the engine
    next_prog_clock = 1'b0;
    next_sample = 1'b0;
    if (debug_prog_enable)
    begin
      next_pin_oe[PIN_PROG_CLOCK] = 1'b0;
      next_pullup[PIN_PROG_CLOCK] = 1'b0;
      next_pin_out[PIN_PROG_DATA] = prog_data_drive;
      next_pin_oe[PIN_PROG_DATA] = prog_data_drive_en;
      next_pullup[PIN_PROG_DATA] = 1'b0;
      next_prog_clock = sense.pin_sync[PIN_PROG_CLOCK];
      next_sample = sense.pin_sync[PIN_PROG_DATA];
    end
    // Interrupt outputs: sticky status level and change request
    next_irq = |(irq_status & irq_enable);
    next_irq_high = int_main[CHANGE_FLAG_BIT] & int_main[CHANGE_ENABLE_BIT]
      & int_edges[CHANGE_PRIO_BIT];
    next_irq_low = int_main[CHANGE_FLAG_BIT] & int_main[CHANGE_ENABLE_BIT]
      & ~int_edges[CHANGE_PRIO_BIT];
  end

  // Every output leaves through a flop so pins see no glitches
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pin_pullup_en <= 8'h00;
      pin_analog_en <= 5'h00;
      capture_unit2_capture <= 1'b0;
      prog_data_sample <= 1'b0;
      prog_serial_clock <= 1'b0;
      prog_mode_entry <= 1'b0;
      irq <= 1'b0;
      port_change_irq_high <= 1'b0;
      port_change_irq_low <= 1'b0;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_pullup_en <= next_pullup;
      pin_analog_en <= next_analog_en;
      capture_unit2_capture <= next_capture;
      prog_data_sample <= next_sample;
      prog_serial_clock <= next_prog_clock;
      prog_mode_entry <= next_entry;
      irq <= next_irq;
      port_change_irq_high <= next_irq_high;
      port_change_irq_low <= next_irq_low;
    end
  end

endmodule : pbg_port

// ==== pbg_pkg.sv ====
// Constants, register map and types for the port B pin block.
// Assumes one 250 MHz system clock and an 8-bit register port.
package pbg_pkg;

  // ****************************************************************
  // Widths and pin positions
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PIN_N = 8;
  localparam int ANALOG_N = 5;
  localparam int CHANGE_N = 4;
  localparam int PIN_CAPTURE = 3;
  localparam int PIN_PROG_ENTRY = 5;
  localparam int PIN_PROG_CLOCK = 6;
  localparam int PIN_PROG_DATA = 7;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] OFS_PIN_LEVELS = 4'h0;
  localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h1;
  localparam logic [3:0] OFS_DIRECTION = 4'h2;
  localparam logic [3:0] OFS_INT_MAIN = 4'h3;
  localparam logic [3:0] OFS_INT_EDGES = 4'h4;
  localparam logic [3:0] OFS_INT_EXTERNAL = 4'h5;
  localparam logic [3:0] OFS_ANALOG_CFG = 4'h6;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h7;
  localparam logic [3:0] OFS_IRQ_CLEAR = 4'h8;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h9;

  // ****************************************************************
  // Implemented bits, reset values and field positions
  // ****************************************************************
  localparam logic [7:0] INT_MAIN_MASK = 8'hFF;
  localparam logic [7:0] INT_EDGES_MASK = 8'hF5;
  localparam logic [7:0] INT_EXTERNAL_MASK = 8'hDB;
  localparam logic [7:0] ANALOG_CFG_MASK = 8'h3F;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIRECTION_RST = 8'hFF;
  localparam logic [7:0] INT_MAIN_RST = 8'h00;
  localparam logic [7:0] INT_EDGES_RST = 8'hF5;
  localparam logic [7:0] INT_EXTERNAL_RST = 8'hC0;
  localparam logic [7:0] ANALOG_CFG_ALL_ANALOG = 8'h00;
  localparam logic [7:0] ANALOG_CFG_ALL_DIGITAL = 8'h0F;
  localparam int CHANGE_FLAG_BIT = 0;
  localparam int CHANGE_ENABLE_BIT = 3;
  localparam int PULLUP_OFF_BIT = 7;
  localparam int CHANGE_PRIO_BIT = 0;
  localparam int STAT_W = 2;
  localparam int STAT_CHANGE_BIT = 0;
  localparam int STAT_PROG_ENTRY_BIT = 1;
  localparam logic [1:0] STAT_RST = 2'h0;
  // Low pin i is analog while the converter field is below its limit
  localparam logic [3:0] ANALOG_LIMIT [ANALOG_N] = '{4'h3, 4'h5, 4'h7, 4'h6, 4'h4};

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PBG_ST_LOAD = 2'b01,
    PBG_ST_RUN = 2'b10
  } pbg_state_t;

endpackage : pbg_pkg

// ==== pbg_sense_if.sv ====
// Carrier between the port core and its pin sensing module.
// Assumes both ends run on the same system clock.
interface pbg_sense_if;
  logic [7:0] pin_sync;
  logic [3:0] compare_mask;
  logic recapture;
  logic mismatch;
  modport core (input pin_sync, input mismatch, output compare_mask, output recapture);
  modport sense (output pin_sync, output mismatch, input compare_mask, input recapture);
endinterface : pbg_sense_if

// ==== pbg_change_sense.sv ====
// Pin synchroniser and change comparison against the reference taken at the last port read or write.
// Assumes pins are asynchronous to sys_clk before this module.
module pbg_change_sense
  import pbg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Raw pins
  input wire logic [pbg_pkg::PIN_N-1:0] pin_in,
  // Core side
  pbg_sense_if.sense sense
);

  logic [PIN_N-1:0] meta;
  logic [PIN_N-1:0] pin_sync;
  logic [CHANGE_N-1:0] reference;
  logic [CHANGE_N-1:0] next_reference;

  // Reference follows the pins only when the port is read or written
  always_comb
  begin
    next_reference = reference;
    if (sense.recapture)
    begin
      next_reference = pin_sync[PIN_N-1:PIN_N-CHANGE_N];
    end
  end

  // Two flops per pin; the first is seen by the second only
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= 8'h00;
      pin_sync <= 8'h00;
      reference <= 4'h0;
    end
    else
    begin
      meta <= pin_in;
      pin_sync <= meta;
      reference <= next_reference;
    end
  end

  // Mismatches of enabled inputs are ORed into one level
  assign sense.mismatch = |((pin_sync[PIN_N-1:PIN_N-CHANGE_N] ^ reference)
    & sense.compare_mask);
  assign sense.pin_sync = pin_sync;

endmodule : pbg_change_sense

// ==== pbg_port_assertions.sv ====
// Checker for the port B pin block, bound to its top module.
// Assumes only the top module's ports are visible.
module pbg_port_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Straps
  input wire logic capture_unit2_pin_select,
  input wire logic low_voltage_prog_enable,
  input wire logic debug_prog_enable,
  // Pins
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [4:0] pin_analog_en,
  // Capture unit and programming
  input wire logic capture_unit2_compare,
  input wire logic capture_unit2_capture,
  input wire logic prog_data_drive,
  input wire logic prog_data_drive_en,
  input wire logic prog_serial_clock,
  input wire logic prog_mode_entry,
  // Interrupts
  input wire logic port_change_irq_high,
  input wire logic port_change_irq_low
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ******
  // Pin and register relations
  // ******
  // Straps get three edges so register latency never trips these
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  pullup_output_a: assert property ((pin_oe & pin_pullup_en) == 8'h00)
    else $error("pull-up on a driven pin");
  clock_off_a: assert property ((!debug_prog_enable)[*3] |-> !prog_serial_clock)
    else $error("programming clock without debug mode");
  clock_pin_a: assert property (debug_prog_enable[*3] |-> !pin_oe[6])
    else $error("clock pin driven in debug mode");
  data_out_a: assert property ((debug_prog_enable && prog_data_drive_en
    && prog_data_drive)[*3] |-> pin_oe[7] && pin_out[7])
    else $error("programming data not driven");
  entry_pin_a: assert property (low_voltage_prog_enable[*3] |-> !pin_oe[5])
    else $error("entry pin driven");
  entry_off_a: assert property ((!low_voltage_prog_enable)[*3] |-> !prog_mode_entry)
    else $error("entry seen without programming strap");
  irq_priority_a: assert property (!(port_change_irq_high && port_change_irq_low))
    else $error("both priorities requested");
  compare_drive_a: assert property ((!capture_unit2_pin_select
    && $stable(capture_unit2_compare))[*3] |-> !pin_oe[3] || pin_out[3] == capture_unit2_compare)
    else $error("compare not on pin");
  capture_in_a: assert property ((!capture_unit2_pin_select && !pin_oe[3] && !pin_analog_en[3]
    && $stable(pin_in[3]))[*4] |-> capture_unit2_capture == pin_in[3]) else $error("bad capture");
  cover property (prog_mode_entry);
  cover property ($rose(port_change_irq_low));
  cover property (capture_unit2_capture);
endmodule : pbg_port_assertions

bind pbg_port pbg_port_assertions chk (.sys_clk, .reset_n, .reg_read, .reg_rdata,
  .capture_unit2_pin_select, .low_voltage_prog_enable, .debug_prog_enable, .pin_in, .pin_out,
  .pin_oe, .pin_pullup_en, .pin_analog_en, .capture_unit2_compare, .capture_unit2_capture,
  .prog_data_drive, .prog_data_drive_en, .prog_serial_clock, .prog_mode_entry,
  .port_change_irq_high, .port_change_irq_low);

// ==== pbg_board.sv ====
// Board circuitry and programming tool around the port pins.
// Assumes device drive wins over the board on a shared pin.
module pbg_board (
  // Clock
  input wire logic sys_clk,
  // Device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  // Board and tool drive
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Resolved levels
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_level = 8'h00;
  // ******
  // Pin resolution
  // ******
  // Floating pins wander, so a stale level never passes for a real one
  always_ff @(posedge sys_clk)
  begin
    last_level <= pin_in;
  end
  // Tool drives clock on pin 6 and data on pin 7 once the device lets go
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last_level[i];
    end
  end
endmodule : pbg_board

// ==== pbg_port_test.sv ====
// Self-checking bench for the port B pin block.
// Assumes the board model and checker are compiled before it.
module pbg_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pbg_pkg::*;
  // ******
  // Stimulus and observed signals
  // ******
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic por_analog_default = 1'b1;
  logic capture_unit2_pin_select = 1'b1;
  logic low_voltage_prog_enable = 1'b0;
  logic debug_prog_enable = 1'b0;
  logic capture_unit2_compare = 1'b0;
  logic prog_data_drive = 1'b0;
  logic prog_data_drive_en = 1'b0;
  logic [7:0] ext_val = 8'hFF;
  logic [7:0] ext_en = 8'hFF;
  logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, pin_pullup_en;
  logic [4:0] pin_analog_en;
  logic capture_unit2_capture, prog_data_sample, prog_serial_clock, prog_mode_entry;
  logic irq, port_change_irq_high, port_change_irq_low;
  int n_errors = 0;
  int n_checks = 0;
  logic [3:0] m_addr [4] = '{OFS_INT_EDGES, OFS_INT_EXTERNAL, OFS_ANALOG_CFG, 4'hF};
  logic [7:0] m_mask [4] = '{INT_EDGES_MASK, INT_EXTERNAL_MASK, ANALOG_CFG_MASK, 8'h00};

  // 4 ns period
  always #2 sys_clk = ~sys_clk;

  pbg_port dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .por_analog_default, .capture_unit2_pin_select, .low_voltage_prog_enable,
    .debug_prog_enable, .pin_in, .pin_out, .pin_oe, .pin_pullup_en, .pin_analog_en,
    .capture_unit2_compare, .capture_unit2_capture, .prog_data_drive, .prog_data_drive_en,
    .prog_data_sample, .prog_serial_clock, .prog_mode_entry, .irq, .port_change_irq_high,
    .port_change_irq_low);
  pbg_board board (.sys_clk, .pin_out, .pin_oe, .pin_pullup_en, .ext_val, .ext_en, .pin_in);

  // ******
  // Access and compare tasks
  // ******
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // One idle cycle after each strobe keeps every signal to one driver per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic pins(input logic [7:0] v);
    @(posedge sys_clk);
    ext_val <= v;
  endtask : pins
  task automatic do_reset(input logic an);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    por_analog_default <= an;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask : do_reset
  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Hang limit
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end

  // ******
  // Scenarios
  // ******
  initial
  begin
    do_reset(1'b1);
    settle(3);
    chk(pin_analog_en, 8'h1F);
    chk(pin_pullup_en, 8'h00);
    rd(OFS_ANALOG_CFG, ANALOG_CFG_ALL_ANALOG);
    rd(OFS_PIN_LEVELS, 8'hE0);
    rd(OFS_DIRECTION, DIRECTION_RST);
    rd(OFS_INT_EDGES, INT_EDGES_RST);
    rd(OFS_INT_EXTERNAL, INT_EXTERNAL_RST);
    do_reset(1'b0);
    settle(3);
    chk(pin_analog_en, 8'h00);
    rd(OFS_ANALOG_CFG, ANALOG_CFG_ALL_DIGITAL);
    foreach (m_addr[i])
    begin
      wr(m_addr[i], 8'hFF);
      rd(m_addr[i], m_mask[i]);
    end
    // Outputs, latch and pull-ups
    wr(OFS_OUTPUT_LATCH, 8'hA5);
    wr(OFS_DIRECTION, 8'h00);
    wr(OFS_ANALOG_CFG, ANALOG_CFG_ALL_ANALOG);
    settle(2);
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'hA5);
    rd(OFS_OUTPUT_LATCH, 8'hA5);
    rd(OFS_PIN_LEVELS, 8'hA5);
    wr(OFS_ANALOG_CFG, ANALOG_CFG_ALL_DIGITAL);
    wr(OFS_INT_EDGES, 8'h74);
    wr(OFS_DIRECTION, 8'hF0);
    settle(2);
    chk(pin_pullup_en, 8'hF0);
    chk(pin_oe, 8'h0F);
    @(posedge sys_clk);
    ext_en <= 8'h00;
    settle(4);
    rd(OFS_PIN_LEVELS, 8'hF5);
    @(posedge sys_clk);
    ext_en <= 8'hFF;
    // Change detection and interrupt
    pins(8'h00);
    settle(3);
    rd(OFS_PIN_LEVELS, 8'h05);
    wr(OFS_IRQ_CLEAR, 8'h03);
    wr(OFS_INT_MAIN, 8'h08);
    wr(OFS_IRQ_ENABLE, 8'h01);
    rd(OFS_INT_MAIN, 8'h08);
    pins(8'h40);
    settle(5);
    chk(irq, 1'b1);
    chk(port_change_irq_low, 1'b1);
    chk(port_change_irq_high, 1'b0);
    wr(OFS_INT_EDGES, 8'h75);
    settle(2);
    chk(port_change_irq_high, 1'b1);
    chk(port_change_irq_low, 1'b0);
    wr(OFS_INT_EDGES, 8'h74);
    rd(OFS_INT_MAIN, 8'h09);
    wr(OFS_INT_MAIN, 8'h08);
    rd(OFS_INT_MAIN, 8'h09);
    rd(OFS_PIN_LEVELS, 8'h45);
    wr(OFS_INT_MAIN, 8'h08);
    rd(OFS_INT_MAIN, 8'h08);
    rd(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_IRQ_CLEAR, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h00);
    pins(8'h00);
    wr(OFS_IRQ_ENABLE, 8'h00);
    settle(3);
    chk(irq, 1'b0);
    rd(OFS_IRQ_STATUS, 8'h01);
    // Programming overrides
    wr(OFS_DIRECTION, 8'h00);
    @(posedge sys_clk);
    low_voltage_prog_enable <= 1'b1;
    settle(3);
    wr(OFS_IRQ_CLEAR, 8'h03);
    pins(8'h20);
    settle(4);
    chk(prog_mode_entry, 1'b1);
    chk(pin_oe[5], 1'b0);
    rd(OFS_IRQ_STATUS, 8'h02);
    @(posedge sys_clk);
    debug_prog_enable <= 1'b1;
    prog_data_drive_en <= 1'b1;
    prog_data_drive <= 1'b1;
    ext_val <= 8'h60;
    settle(4);
    chk(pin_oe & 8'hC0, 8'h80);
    chk(pin_out[7], 1'b1);
    chk(prog_serial_clock, 1'b1);
    chk(prog_data_sample, 1'b1);
    // Tool drives 0 after the engine let go of a driven 1
    @(posedge sys_clk);
    prog_data_drive_en <= 1'b0;
    ext_val <= 8'h20;
    settle(4);
    chk(prog_data_sample, 1'b0);
    chk(prog_serial_clock, 1'b0);
    // Capture unit on pin 3
    @(posedge sys_clk);
    capture_unit2_pin_select <= 1'b0;
    capture_unit2_compare <= 1'b1;
    settle(3);
    chk(pin_out[3], 1'b1);
    wr(OFS_DIRECTION, 8'h08);
    pins(8'hA8);
    settle(5);
    chk(capture_unit2_capture, 1'b1);
    tally_and_finish();
  end
endmodule : pbg_port_test
